// ===== hdl/serial_flash_erase_protect.sv
// Functional notes
// [R1] 20h erases 4-Kbyte block; 52h or D8h erases 32-Kbyte block.
// [R2] Program, erase, status-write run only if the write-enable latch was already set.
// [R3] Block erase: opcode plus three address bytes, extras ignored, starts at deselect.
// [R4] Address bits A11-A0 or A14-A0 ignored; upper bits pick the block.
// [R5] Block erase aborts if address incomplete or deselect off a byte boundary.
// [R6] Protected array: block erase skipped, back to idle at deselect.
// [R7] Aborted or protected block erase clears the write-enable latch.
// [R8] Busy shown during erase; latch cleared before the erase finishes.
// [R9] Byte failing to erase sets the erase/program error flag.
// [R10] Host should poll busy rather than wait the worst-case erase time.
// [R11] 60h, 62h, C7h are identical chip erase codes; no address; extras ignored.
// [R12] Chip erase needs full opcode and deselect on a byte boundary.
// [R13] Protected array: chip erase skipped, back to idle at deselect.
// [R14] Rejected chip erase clears the write-enable latch.
// [R15] 06h sets the write-enable latch at deselect; extras ignored.
// [R16] Incomplete or misaligned latch set/clear aborts, latch unchanged.
// [R17] 04h clears the write-enable latch at deselect.
// [R18] Protect bit 0 means no protection; 1 protects up to 01FFFFh.
// [R19] Protect bit 1 blocks program, block erase and chip erase.
// [R20] Protect bit changed by status write, lockable by write-protect pin and lock bit.
// [R21] Protect bit is nonvolatile and reads 0 as delivered; here it is a register that every reset loads with 0.
// [R22] System should set protect bit before power-down for protection at power-up.
// [R23] Hardware lock only with pin asserted and lock bit 1; blocks status writes.
// [R24] Bytes shift MSB first, sampled on rising serial clock, mode 0 or 3.
`include "serial_flash_regs.svh"

module serial_flash_erase_protect
  import serial_flash_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic sck,
  input wire logic csN,
  input wire logic mosi,
  input wire logic wpN,
  input wire logic arrayDone,
  input wire logic arrayFail,
  output logic eraseReq,
  output logic [23:0] eraseBase,
  output eraseKind_t eraseKind,
  output logic busy,
  output logic writeEnableLatch,
  output logic arrayProtectBit,
  output logic protectionLockBit,
  output logic eraseProgramErrorFlag,
  output logic hardwareLocked
);

  // Serial clock domain
  logic fresh_r;
  logic [6:0] shift_r;
  frame_t link_r;
  frame_t link_nxt;
  logic [2:0] bitPhaseInc;
  logic [7:0] byteIn;
  logic byteDone;
  logic [2:0] byteIdx;

  // Frame start marker, set while deselected
  always_ff @(posedge sck or posedge csN or negedge resetn)
  begin
    if (!resetn)
    begin
      fresh_r <= 1'b1;
    end
    else if (csN)
    begin
      fresh_r <= 1'b1;
    end
    else
    begin
      fresh_r <= 1'b0;
    end
  end

  assign bitPhaseInc = fresh_r ? 3'h1 : 3'(link_r.bitPhase + 3'h1);
  assign byteDone = !fresh_r && (link_r.bitPhase == 3'h7);
  assign byteIn = {shift_r, mosi}; // [R24]
  assign byteIdx = fresh_r ? 3'h0 : link_r.bytes;

  always_comb
  begin
    link_nxt = link_r;
    link_nxt.bitPhase = bitPhaseInc;
    if (fresh_r)
    begin
      link_nxt.bytes = 3'h0;
      link_nxt.tag = ~link_r.tag;
    end
    if (byteDone)
    begin
      if (byteIdx != `LEN_SAT)
      begin
        link_nxt.bytes = 3'(byteIdx + 3'h1);
      end
      case (byteIdx)
        3'h0: link_nxt.opcode = byteIn;
        3'h1:
        begin
          link_nxt.addr[23:16] = byteIn;
          link_nxt.data = byteIn;
        end
        3'h2: link_nxt.addr[15:8] = byteIn;
        3'h3: link_nxt.addr[7:0] = byteIn;
        default: link_nxt.opcode = link_r.opcode; // [R3] [R11]
      endcase
    end
  end

  // Serial clock edges while deselected, such as a change of idle level, leave the frame alone
  always_ff @(posedge sck or negedge resetn)
  begin
    if (!resetn)
    begin
      shift_r <= 7'h00;
      link_r <= '0;
    end
    else if (!csN)
    begin
      shift_r <= {shift_r[5:0], mosi}; // [R24]
      link_r <= link_nxt;
    end
  end

  // Core clock domain
  logic csSync;
  logic wpSyncN;
  logic csPrev_r;
  logic csRise;
  logic act_r;
  logic lastTag_r;
  frame_t frm_r;
  state_t state_r;
  state_t state_nxt;

  sync_two_flop #(
    .W(1),
    .RESET_VAL(1'b1)
  ) u_cs_sync (
    .clock(clock),
    .resetn(resetn),
    .din(csN),
    .dout(csSync)
  );

  sync_two_flop #(
    .W(1),
    .RESET_VAL(1'b1)
  ) u_wp_sync (
    .clock(clock),
    .resetn(resetn),
    .din(wpN),
    .dout(wpSyncN)
  );

  assign csRise = csSync && !csPrev_r;

  // Link frame is stable after deselect until the next serial clock edge
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      csPrev_r <= 1'b1;
      act_r <= 1'b0;
      frm_r <= '0;
    end
    else
    begin
      csPrev_r <= csSync;
      act_r <= csRise;
      if (csRise)
      begin
        frm_r <= link_r;
      end
    end
  end

  // Frame decode
  logic newFrame;
  logic aligned;
  logic hasOpcode;
  logic hasAddr;
  logic hasData;
  logic isBlk4;
  logic isBlk32;
  logic isBlock;
  logic isChip;
  logic isWren;
  logic isWrdi;
  logic isWrsr;
  logic cmdValid;
  logic blockOk;
  logic chipOk;
  logic eraseGo;
  logic eraseReject;
  logic statusGo;
  logic wpAsserted;

  assign newFrame = act_r && (frm_r.tag != lastTag_r) && (state_r == ST_IDLE);
  assign aligned = frm_r.bitPhase == 3'h0; // [R5] [R12] [R16]
  assign hasOpcode = frm_r.bytes >= `LEN_OPCODE;
  assign hasData = frm_r.bytes >= `LEN_STATUS;
  assign hasAddr = frm_r.bytes >= `LEN_BLOCK;
  assign cmdValid = newFrame && hasOpcode;
  assign isBlk4 = frm_r.opcode == `OP_ERASE_4K; // [R1]
  assign isBlk32 = (frm_r.opcode == `OP_ERASE_32K_A) || (frm_r.opcode == `OP_ERASE_32K_B); // [R1]
  assign isBlock = cmdValid && (isBlk4 || isBlk32);
  assign isChip = cmdValid && ((frm_r.opcode == `OP_CHIP_A) || (frm_r.opcode == `OP_CHIP_B)
                               || (frm_r.opcode == `OP_CHIP_C)); // [R11]
  assign isWren = cmdValid && (frm_r.opcode == `OP_WR_ENABLE);
  assign isWrdi = cmdValid && (frm_r.opcode == `OP_WR_DISABLE);
  assign isWrsr = cmdValid && (frm_r.opcode == `OP_WR_STATUS);

  assign blockOk = isBlock && aligned && hasAddr; // [R3] [R5]
  assign chipOk = isChip && aligned; // [R12]
  assign eraseGo = (blockOk || chipOk) && !arrayProtectBit && writeEnableLatch; // [R2] [R6] [R13] [R19]
  assign eraseReject = (isBlock && !(blockOk && !arrayProtectBit))
                       || (isChip && !(chipOk && !arrayProtectBit)); // [R7] [R14]

  assign wpAsserted = !wpSyncN;
  assign hardwareLocked = wpAsserted && protectionLockBit; // [R23]
  assign statusGo = isWrsr && aligned && hasData && writeEnableLatch && !hardwareLocked; // [R2] [R20] [R23]

  // Erase sequencer
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (eraseGo)
        begin
          state_nxt = ST_ERASE;
        end
      end
      ST_ERASE:
      begin
        if (arrayDone)
        begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  logic [23:0] base_nxt;
  eraseKind_t kind_nxt;

  assign kind_nxt = isChip ? ERASE_CHIP : (isBlk4 ? ERASE_4K : ERASE_32K);
  assign base_nxt = isChip ? 24'h000000 :
                    (isBlk4 ? {frm_r.addr[23:`BLK4_LSB], 12'h000} // [R4]
                            : {frm_r.addr[23:`BLK32_LSB], 15'h0000}); // [R4]

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      lastTag_r <= 1'b0;
      eraseReq <= 1'b0;
      eraseBase <= 24'h000000;
      eraseKind <= ERASE_NONE;
    end
    else
    begin
      state_r <= state_nxt;
      if (act_r)
      begin
        lastTag_r <= frm_r.tag;
      end
      if (eraseGo)
      begin
        eraseReq <= 1'b1; // [R3] [R11]
        eraseBase <= base_nxt;
        eraseKind <= kind_nxt;
      end
      else if (arrayDone)
      begin
        eraseReq <= 1'b0;
        eraseKind <= ERASE_NONE;
      end
    end
  end

  assign busy = state_r == ST_ERASE; // [R8]

  // Write-enable latch
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      writeEnableLatch <= 1'b0;
    end
    else if (isWren && aligned)
    begin
      writeEnableLatch <= 1'b1; // [R15] [R16]
    end
    else if (isWrdi && aligned)
    begin
      writeEnableLatch <= 1'b0; // [R17] [R16]
    end
    else if (eraseGo || eraseReject || statusGo)
    begin
      writeEnableLatch <= 1'b0; // [R7] [R8] [R14]
    end
  end

  // Protection bits
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      arrayProtectBit <= `PROTECT_RESET; // [R21]
      protectionLockBit <= `LOCK_RESET;
    end
    else if (statusGo)
    begin
      arrayProtectBit <= frm_r.data[`SR_PROTECT_BIT]; // [R18] [R20]
      protectionLockBit <= frm_r.data[`SR_LOCK_BIT];
    end
  end

  // Erase error flag; a failure report wins over the clear at erase start
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      eraseProgramErrorFlag <= 1'b0;
    end
    else if (busy && arrayFail)
    begin
      eraseProgramErrorFlag <= 1'b1; // [R9]
    end
    else if (eraseGo)
    begin
      eraseProgramErrorFlag <= 1'b0;
    end
  end

endmodule : serial_flash_erase_protect

// ===== include/serial_flash_regs.svh
`ifndef SERIAL_FLASH_REGS_SVH
`define SERIAL_FLASH_REGS_SVH

// Command codes
`define OP_ERASE_4K 8'h20
`define OP_ERASE_32K_A 8'h52
`define OP_ERASE_32K_B 8'hd8
`define OP_CHIP_A 8'h60
`define OP_CHIP_B 8'h62
`define OP_CHIP_C 8'hc7
`define OP_WR_ENABLE 8'h06
`define OP_WR_DISABLE 8'h04
`define OP_WR_STATUS 8'h01

// Bytes a frame must carry
`define LEN_OPCODE 3'h1
`define LEN_STATUS 3'h2
`define LEN_BLOCK 3'h4
`define LEN_SAT 3'h4

// Status-write data bit positions
`define SR_PROTECT_BIT 2
`define SR_LOCK_BIT 7

// Block address bits kept
`define BLK4_LSB 12
`define BLK32_LSB 15
`define ADDR_W 24

// Reset values
`define PROTECT_RESET 1'h0
`define LOCK_RESET 1'h0

`endif

// ===== include/serial_flash_pkg.sv
package serial_flash_pkg;

  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] data;
    logic [2:0] bytes;
    logic [2:0] bitPhase;
    logic tag;
  } frame_t;

  typedef enum logic [1:0] {
    ERASE_NONE = 2'b00,
    ERASE_4K = 2'b01,
    ERASE_32K = 2'b10,
    ERASE_CHIP = 2'b11
  } eraseKind_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_ERASE = 1'b1
  } state_t;

endpackage : serial_flash_pkg

// ===== hdl/sync_two_flop.sv
module sync_two_flop #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] stage_r;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      stage_r <= RESET_VAL;
      dout <= RESET_VAL;
    end
    else
    begin
      stage_r <= din;
      dout <= stage_r;
    end
  end

endmodule : sync_two_flop

// ===== tb/serial_flash_erase_protect_monitor.sv
module serial_flash_erase_protect_monitor
  import serial_flash_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic arrayDone,
  input wire logic arrayFail,
  input wire logic eraseReq,
  input wire logic [23:0] eraseBase,
  input wire eraseKind_t eraseKind,
  input wire logic busy,
  input wire logic writeEnableLatch,
  input wire logic arrayProtectBit,
  input wire logic protectionLockBit,
  input wire logic hardwareLocked,
  input wire logic eraseProgramErrorFlag,
  input wire logic wpN
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  sequence s_start;
    $rose(eraseReq);
  endsequence
  sequence s_done;
    busy && arrayDone;
  endsequence
  a_start_latch: assert property (s_start |-> $past(writeEnableLatch) && !writeEnableLatch)
    else $error("erase start without latch");
  a_start_open: assert property (s_start |-> !arrayProtectBit && eraseKind != ERASE_NONE)
    else $error("erase start while protected");
  a_req_busy: assert property (eraseReq |-> busy)
    else $error("request without busy");
  a_done_idle: assert property (s_done |=> !busy && !eraseReq)
    else $error("erase not ended");
  a_fail_flag: assert property (busy && arrayFail |=> eraseProgramErrorFlag)
    else $error("error flag not set");
  a_base_4k: assert property (eraseReq && eraseKind == ERASE_4K |-> eraseBase[11:0] == 12'h000)
    else $error("small block base");
  a_base_32k: assert property (eraseReq && eraseKind == ERASE_32K |-> eraseBase[14:0] == 15'h0000)
    else $error("large block base");
  a_base_chip: assert property (eraseReq && eraseKind == ERASE_CHIP |-> eraseBase == 24'h000000)
    else $error("chip base");
  a_lock_bit: assert property (hardwareLocked == (!$past(wpN, 2) && protectionLockBit))
    else $error("lock state mismatch");
  a_locked_hold: assert property (hardwareLocked |=> $stable(arrayProtectBit))
    else $error("protect changed while locked");
endmodule : serial_flash_erase_protect_monitor

bind serial_flash_erase_protect serial_flash_erase_protect_monitor u_serial_flash_erase_protect_monitor (
  .clock, .resetn, .arrayDone, .arrayFail, .eraseReq, .eraseBase, .eraseKind, .busy,
  .writeEnableLatch, .arrayProtectBit, .protectionLockBit, .hardwareLocked,
  .eraseProgramErrorFlag, .wpN);

// ===== tb/spi_host_model.sv
module spi_host_model (
  output logic sck,
  output logic csN,
  output logic mosi
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    sck = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
  end
  // Mode 0 or mode 3 frame, clock still between frames
  task automatic send(input logic [39:0] bits, input int n, input logic cpol);
    sck = cpol;
    #8 csN = 1'b0;
    #7;
    for (int i = 39; i > 39 - n; i--)
    begin
      sck = 1'b0;
      mosi = bits[i];
      #16 sck = 1'b1;
      #16;
    end
    sck = cpol;
    #9 csN = 1'b1;
    mosi = ~mosi;
  endtask : send
endmodule : spi_host_model

// ===== tb/serial_flash_erase_protect_test.sv
module serial_flash_erase_protect_test;
  timeunit 1ns;
  timeprecision 100ps;
  import serial_flash_pkg::*;
  logic clock, resetn, wpN, arrayDone, arrayFail, sck, csN, mosi;
  logic eraseReq, busy, writeEnableLatch, arrayProtectBit, protectionLockBit, eraseProgramErrorFlag, hardwareLocked;
  logic [23:0] eraseBase;
  eraseKind_t eraseKind;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  logic spiMode3 = 1'b0;
  serial_flash_erase_protect u_serial_flash_erase_protect (.clock, .resetn, .sck, .csN, .mosi, .wpN,
    .arrayDone, .arrayFail, .eraseReq, .eraseBase, .eraseKind, .busy, .writeEnableLatch,
    .arrayProtectBit, .protectionLockBit, .eraseProgramErrorFlag, .hardwareLocked);
  spi_host_model u_spi_host_model (.sck, .csN, .mosi);
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cmd(input logic [7:0] op, input logic [23:0] addr, input int n);
    u_spi_host_model.send({op, addr, 8'h5a}, n, spiMode3);
    repeat (10) @(negedge clock);
  endtask : cmd
  task automatic pulse(input logic fail);
    arrayFail = fail;
    @(negedge clock);
    arrayDone = 1'b1;
    @(negedge clock);
    arrayDone = 1'b0;
    arrayFail = 1'b0;
    @(negedge clock);
    check({busy, eraseReq, eraseKind, eraseProgramErrorFlag}, {4'b0000, fail});
  endtask : pulse
  task automatic t_latch();
    cmd(8'h06, 0, 7);
    check(writeEnableLatch, 0);
    cmd(8'h06, 0, 16);
    check(writeEnableLatch, 1);
    cmd(8'h04, 0, 12);
    check(writeEnableLatch, 1);
    cmd(8'h04, 0, 8);
    check(writeEnableLatch, 0);
  endtask : t_latch
  task automatic t_block();
    logic [7:0] ops[3] = '{8'h20, 8'h52, 8'hd8};
    for (int i = 0; i < 3; i++)
    begin
      cmd(8'h06, 0, 8);
      cmd(ops[i], 24'h01abcd, i == 0 ? 40 : 32);
      check({eraseReq, busy, writeEnableLatch}, 3'b110);
      check(eraseKind, i == 0 ? 1 : 2);
      check(eraseBase, i == 0 ? 24'h01a000 : 24'h018000);
      cmd(8'h06, 0, 8);
      check(writeEnableLatch, 0);
      pulse(i == 1);
    end
  endtask : t_block
  task automatic t_reject();
    cmd(8'h20, 24'h001000, 32);
    check(eraseReq, 0);
    cmd(8'h06, 0, 8);
    cmd(8'h20, 24'h001000, 24);
    check({eraseReq, writeEnableLatch}, 0);
    cmd(8'h06, 0, 8);
    cmd(8'h52, 24'h001000, 33);
    check({eraseReq, writeEnableLatch}, 0);
    cmd(8'h06, 0, 8);
    cmd(8'hc7, 0, 9);
    check({eraseReq, writeEnableLatch}, 0);
  endtask : t_reject
  task automatic t_chip();
    logic [7:0] ops[3] = '{8'h60, 8'h62, 8'hc7};
    spiMode3 = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      cmd(8'h06, 0, 8);
      cmd(ops[i], 24'hffffff, 8 + 8 * i);
      check({eraseReq, eraseKind, eraseBase}, {3'b111, 24'h000000});
      pulse(0);
    end
    cmd(8'h06, 0, 8);
    cmd(8'h62, 0, 15);
    check({eraseReq, writeEnableLatch}, 0);
    spiMode3 = 1'b0;
  endtask : t_chip
  task automatic t_protect();
    cmd(8'h06, 0, 8);
    cmd(8'h01, 24'h04ffff, 16);
    check(arrayProtectBit, 1);
    cmd(8'h06, 0, 8);
    cmd(8'h20, 24'h000000, 32);
    check({eraseReq, writeEnableLatch}, 0);
    cmd(8'h06, 0, 8);
    cmd(8'h60, 0, 8);
    check({eraseReq, writeEnableLatch}, 0);
    cmd(8'h06, 0, 8);
    cmd(8'h01, 24'h84ffff, 16);
    wpN = 1'b0;
    repeat (4) @(negedge clock);
    check({hardwareLocked, protectionLockBit}, 2'b11);
    cmd(8'h06, 0, 8);
    cmd(8'h01, 0, 16);
    check(arrayProtectBit, 1);
    wpN = 1'b1;
    cmd(8'h06, 0, 8);
    cmd(8'h01, 0, 16);
    check({hardwareLocked, arrayProtectBit, protectionLockBit}, 0);
    cmd(8'h01, 24'h04ffff, 16);
    check(arrayProtectBit, 0);
    cmd(8'h06, 0, 8);
    cmd(8'h01, 24'h04ffff, 16);
    check({arrayProtectBit, writeEnableLatch}, 2'b10);
  endtask : t_protect
  initial
  begin
    resetn = 1'b1;
    wpN = 1'b1;
    arrayDone = 1'b0;
    arrayFail = 1'b0;
    #1 resetn = 1'b0;
    repeat (10) @(negedge clock);
    resetn = 1'b1;
    repeat (4) @(negedge clock);
    check({busy, writeEnableLatch, arrayProtectBit, protectionLockBit}, 0);
    check({eraseReq, eraseKind, eraseProgramErrorFlag, hardwareLocked}, 0);
    t_latch();
    t_block();
    t_reject();
    t_chip();
    t_protect();
    report_and_stop();
  end
endmodule : serial_flash_erase_protect_test
